// ===== hdl/floppy_host_io_pkg.sv
// constants, carriers and states of the floppy host i/o interface
package floppy_host_io_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned GAP12_MS = 23;
  localparam int unsigned GAP8_MS = 18;
  localparam real INIT_S = 1.8;
  localparam int unsigned GAP12_CYC = GAP12_MS * (CLK_HZ / 1000);
  localparam int unsigned GAP8_CYC = GAP8_MS * (CLK_HZ / 1000);
  // longest time, so rounded down
  localparam int unsigned INIT_CYC = int'($floor(INIT_S * CLK_HZ));
  // ----------------------------------------------------------------
  // words per sector and buffer
  // ----------------------------------------------------------------
  localparam logic [8:0] WORDS_12_SD = 9'd64;
  localparam logic [8:0] WORDS_8_SD = 9'd128;
  localparam logic [8:0] WORDS_12_DD = 9'd128;
  localparam logic [8:0] WORDS_8_DD = 9'd256;
  localparam int unsigned BUF_DEPTH = 256;
  localparam logic [7:0] BUF_LAST = 8'hff;
  // ----------------------------------------------------------------
  // accumulator fields; values are vector indices, bit 0 is the lsb
  // ----------------------------------------------------------------
  localparam int unsigned FUNC_HI = 3;
  localparam int unsigned FUNC_LO = 1;
  localparam int unsigned DRV_BIT = 4;
  localparam int unsigned MODE8_BIT = 6;
  localparam int unsigned DENS_BIT = 8;
  localparam int unsigned DENS2_BIT = 1;
  localparam int unsigned IE_BIT = 0;
  localparam logic [2:0] DEV_HI = 3'h7;
  // ----------------------------------------------------------------
  // instruction and function codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_LOAD = 3'h1;
  localparam logic [2:0] OP_XFER = 3'h2;
  localparam logic [2:0] OP_SKIPREQ = 3'h3;
  localparam logic [2:0] OP_SKIPERR = 3'h4;
  localparam logic [2:0] OP_SKIPDONE = 3'h5;
  localparam logic [2:0] OP_IE = 3'h6;
  localparam logic [2:0] OP_INIT = 3'h7;
  localparam logic [2:0] FN_FILL = 3'h0;
  localparam logic [2:0] FN_EMPTY = 3'h1;
  // ----------------------------------------------------------------
  // register map on the ahb side
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ESW = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_BADR = 8'h0c;
  localparam logic [7:0] A_BDAT = 8'h10;
  localparam int unsigned CTL_FIN = 0;
  localparam int unsigned CTL_ERR = 1;
  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [5:0] dev;
    logic [2:0] op;
    logic [11:0] acc;
  } instr_req_t;
  typedef struct packed {
    logic load;
    logic skip;
    logic [11:0] acc;
  } instr_rsp_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD2, ST_WAIT, ST_GAP, ST_PAD, ST_DRIVE, ST_INIT
  } state_t;
endpackage

// ===== hdl/floppy_host_io_interface.sv
// host i/o instruction interface of a two-drive floppy subsystem
//
// Summary of operation
// [RL1] 12-bit single density: 64 host words per sector.
// [RL2] 8-bit single density: 128 bytes per sector, sector fully packed.
// [RL3] 12-bit mode: after the host words, pad the rest of buffer with zeros.
// [RL4] next transfer request 23 ms after service in 12-bit, 18 ms in 8-bit.
// [RL5] no timeout waiting for the host; no data lost however late.
// [RL6] double density: 128 twelve-bit words or 256 bytes per sector.
// [RL7] match device field: high three bits ones, low three from switches.
// [RL8] op 0 nop, 1 load, 2 transfer, 3-5 skips, 6 irq enable, 7 init.
// [RL9] load command copies accumulator, clears it, starts coded function on drive.
// [RL10] no new function until previous completes; host waits for completion.
// [RL11] double density 8-bit: first byte, request, second byte, then function.
// [RL12] transfer while not done moves one word and lets the device proceed.
// [RL13] transfer to device leaves accumulator; 8-bit ignores its top nibble.
// [RL14] reads jam 12 bits, or OR byte into low eight bits.
// [RL15] when done, transfer returns the error status word in current mode.
// [RL16] skip on request: skip if flag set, then clear it.
// [RL17] host tests request flag before transfers and after a command load.
// [RL18] skip on error: skip if set, clear; any error sets done.
// [RL19] skip on done: skip if set, clear it.
// [RL20] irq enable follows accumulator lsb; done requests interrupt when enabled.
// [RL21] initialize clears status word and sets done within 1.8 seconds.
// [RL22] initialize from instruction or from the bus initialize line.
// [RL23] command: function, drive select, word length and density at fixed bits.
// [RL24] after any initialize the word mode is 12-bit.
// [RL25] instructions for other device codes change nothing at all.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
module floppy_host_io_interface
  import floppy_host_io_pkg::*;
#(
  parameter bit DD_IF = 1'b1,
  parameter int unsigned GAP12 = GAP12_CYC,
  parameter int unsigned GAP8 = GAP8_CYC,
  parameter int unsigned INIT_LEN = INIT_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // host instruction port
  input wire instr_req_t i_instr,
  input wire logic i_bus_init,
  input wire logic [2:0] i_dev_switch,
  output instr_rsp_t o_instr,
  output logic o_irq,
  // ahb-lite slave, drive side
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0] idx_reg, idx_next, badr_reg, wadr_reg;
  logic [11:0] ir_reg, ir_next, esw_reg, buf_wd;
  logic [11:0] mem [BUF_DEPTH];
  logic [2:0] func_reg, func_next;
  logic drv_reg, drv_next, mode8_reg, mode8_next, dens_reg, dens_next;
  logic req_reg, done_reg, err_reg, ie_reg, wr_pend_reg;
  logic req_set, done_set, err_set, start, buf_we, last;
  logic hit, load_cmd, xfer_word, skip_req, skip_err, skip_done, ie_i, init_go, w_fin, w_err;
  logic [8:0] wcount;

  // instruction decode; mismatched codes never reach any logic
  assign hit = i_instr.valid && i_instr.dev == {DEV_HI, i_dev_switch}; // [RL7] [RL25]
  assign load_cmd = hit && i_instr.op == OP_LOAD; // [RL8]
  assign xfer_word = hit && i_instr.op == OP_XFER;
  assign skip_req = hit && i_instr.op == OP_SKIPREQ;
  assign skip_err = hit && i_instr.op == OP_SKIPERR;
  assign skip_done = hit && i_instr.op == OP_SKIPDONE;
  assign ie_i = hit && i_instr.op == OP_IE;
  assign init_go = i_bus_init || (hit && i_instr.op == OP_INIT); // [RL22]

  // drive-side writes land in the ahb data phase
  assign w_fin = wr_pend_reg && wadr_reg == A_CTRL && i_hwdata[CTL_FIN];
  assign w_err = wr_pend_reg && wadr_reg == A_CTRL && i_hwdata[CTL_ERR];
  // an error ends whatever function is running, not an initialize
  assign err_set = w_err && state_reg != ST_IDLE && state_reg != ST_INIT; // [RL18]

  // words per sector by mode and density
  always_comb begin
    if (mode8_reg) begin
      wcount = dens_reg ? WORDS_8_DD : WORDS_8_SD; // [RL2] [RL6]
    end else begin
      wcount = dens_reg ? WORDS_12_DD : WORDS_12_SD; // [RL1] [RL6]
    end
  end
  assign last = {1'b0, idx_reg} == wcount - 9'd1;

  // ----------------------------------------------------------------
  // function sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    ir_next = ir_reg;
    func_next = func_reg;
    drv_next = drv_reg;
    mode8_next = mode8_reg;
    dens_next = dens_reg;
    req_set = 1'b0;
    done_set = 1'b0;
    start = 1'b0;
    buf_we = 1'b0;
    buf_wd = 12'h000;
    case (state_reg)
      ST_IDLE: begin
        // a load while busy is simply not seen here
        if (load_cmd) begin // [RL10]
          ir_next = i_instr.acc; // [RL9]
          func_next = i_instr.acc[FUNC_HI:FUNC_LO]; // [RL23]
          drv_next = i_instr.acc[DRV_BIT];
          mode8_next = i_instr.acc[MODE8_BIT];
          dens_next = DD_IF ? i_instr.acc[DENS_BIT] : 1'b0;
          if (DD_IF && i_instr.acc[MODE8_BIT]) begin
            state_next = ST_CMD2; // [RL11]
            req_set = 1'b1;
          end else begin
            start = 1'b1;
          end
        end
      end
      ST_CMD2: begin
        // second byte holds density in its bit 1, not bit 0
        if (xfer_word) begin
          dens_next = i_instr.acc[DENS2_BIT]; // [RL11]
          start = 1'b1;
        end
      end
      ST_WAIT: begin
        // waits here forever; the word stays put until the host comes
        if (xfer_word) begin // [RL5] [RL12]
          if (func_reg == FN_FILL) begin
            buf_we = 1'b1;
            buf_wd = mode8_reg ? {4'h0, i_instr.acc[7:0]} : i_instr.acc; // [RL13]
            ir_next = i_instr.acc;
          end
          idx_next = idx_reg + 8'd1;
          if (last) begin
            if (func_reg == FN_FILL && !mode8_reg) begin
              state_next = ST_PAD; // [RL3]
            end else begin
              state_next = ST_IDLE;
              done_set = 1'b1;
            end
          end else begin
            state_next = ST_GAP;
            cnt_next = mode8_reg ? GAP8 - 1 : GAP12 - 1; // [RL4]
          end
        end
      end
      ST_GAP: begin
        if (cnt_reg == 32'h0000_0000) begin
          state_next = ST_WAIT; // [RL4]
          req_set = 1'b1;
          if (func_reg == FN_EMPTY) begin
            ir_next = mem[idx_reg];
          end
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      ST_PAD: begin
        // zero the tail so a short 12-bit sector records clean
        buf_we = 1'b1; // [RL3]
        idx_next = idx_reg + 8'd1;
        if (idx_reg == BUF_LAST) begin
          state_next = ST_IDLE;
          done_set = 1'b1;
        end
      end
      ST_DRIVE: begin
        if (w_fin) begin
          state_next = ST_IDLE;
          done_set = 1'b1;
        end
      end
      ST_INIT: begin
        if (cnt_reg == 32'h0000_0000) begin
          state_next = ST_IDLE; // [RL21]
          done_set = 1'b1;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // launch the coded function once the command is complete
    if (start) begin // [RL9]
      idx_next = 8'h00;
      if (func_next == FN_FILL || func_next == FN_EMPTY) begin
        state_next = ST_WAIT;
        req_set = 1'b1;
        if (func_next == FN_EMPTY) begin
          ir_next = mem[0];
        end
      end else begin
        state_next = ST_DRIVE;
      end
    end
    if (err_set) begin
      state_next = ST_IDLE; // [RL18]
      done_set = 1'b1;
    end
    // initialize beats everything else in flight
    if (init_go) begin
      state_next = ST_INIT; // [RL21] [RL22]
      cnt_next = INIT_LEN - 1;
      ir_next = 12'h000;
      idx_next = 8'h00;
      mode8_next = 1'b0; // [RL24]
      dens_next = 1'b0;
      req_set = 1'b0;
      done_set = 1'b0;
      buf_we = 1'b0;
    end
  end

  // sequencer state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 32'h0000_0000;
      idx_reg <= 8'h00;
      ir_reg <= 12'h000;
      func_reg <= 3'h0;
      drv_reg <= 1'b0;
      mode8_reg <= 1'b0;
      dens_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      ir_reg <= ir_next;
      func_reg <= func_next;
      drv_reg <= drv_next;
      mode8_reg <= mode8_next;
      dens_reg <= dens_next;
    end
  end

  // ----------------------------------------------------------------
  // flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      ie_reg <= 1'b0;
    end else if (init_go) begin
      req_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      ie_reg <= 1'b0;
    end else begin
      req_reg <= req_set || (req_reg && !skip_req); // [RL16]
      done_reg <= done_set || (done_reg && !skip_done); // [RL19] [RL18]
      err_reg <= err_set || (err_reg && !skip_err); // [RL18]
      if (ie_i) begin
        ie_reg <= i_instr.acc[IE_BIT]; // [RL20]
      end
    end
  end
  assign o_irq = done_reg && ie_reg; // [RL20]

  // error status word; the drive side fills it, initialize zeros it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      esw_reg <= 12'h000;
    end else if (init_go) begin
      esw_reg <= 12'h000; // [RL21]
    end else if (wr_pend_reg && wadr_reg == A_ESW) begin
      esw_reg <= i_hwdata[11:0];
    end
  end

  // sector buffer; the sequencer has the port before the drive side
  always_ff @(posedge i_clk) begin
    if (buf_we) begin
      mem[idx_reg] <= buf_wd;
    end else if (wr_pend_reg && wadr_reg == A_BDAT) begin
      mem[badr_reg] <= i_hwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // answers to the host: registered one cycle after the instruction
  // ----------------------------------------------------------------
  function automatic logic [11:0] to_acc(input logic [11:0] w, input logic [11:0] acc,
                                         input logic m8);
    // 8-bit mode ors the byte in and keeps the top nibble
    to_acc = m8 ? {acc[11:8], acc[7:0] | w[7:0]} : w;
  endfunction

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_instr <= '0;
    end else begin
      o_instr.load <= 1'b0;
      o_instr.skip <= 1'b0;
      if (load_cmd && state_reg == ST_IDLE) begin
        o_instr.load <= 1'b1; // [RL9]
        o_instr.acc <= 12'h000;
      end else if (xfer_word && state_reg == ST_WAIT && func_reg == FN_EMPTY) begin
        o_instr.load <= 1'b1; // [RL14] [RL12]
        o_instr.acc <= to_acc(ir_reg, i_instr.acc, mode8_reg);
      end else if (xfer_word && state_reg == ST_IDLE) begin
        o_instr.load <= 1'b1; // [RL15]
        o_instr.acc <= to_acc(esw_reg, i_instr.acc, mode8_reg);
      end
      if (skip_req) begin
        o_instr.skip <= req_reg; // [RL16]
      end else if (skip_err) begin
        o_instr.skip <= err_reg; // [RL18]
      end else if (skip_done) begin
        o_instr.skip <= done_reg; // [RL19]
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ----------------------------------------------------------------
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // latch writes for the data phase, read data ready by then
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      wadr_reg <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      wadr_reg <= i_haddr[7:0];
      if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
        case (i_haddr[7:0])
          A_ESW: o_hrdata <= {20'h0_0000, esw_reg};
          A_STAT: o_hrdata <= {21'h00_0000, state_reg != ST_IDLE, func_reg, drv_reg,
                               mode8_reg, dens_reg, req_reg, err_reg, done_reg, ie_reg};
          A_BADR: o_hrdata <= {24'h00_0000, badr_reg};
          A_BDAT: o_hrdata <= {20'h0_0000, mem[badr_reg]};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // buffer pointer for the drive side
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      badr_reg <= 8'h00;
    end else if (wr_pend_reg && wadr_reg == A_BADR) begin
      badr_reg <= i_hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_nomatch;
    i_instr.valid && !hit |=> !o_instr.load && !o_instr.skip;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign code answered"); // [RL25]
  property p_lcd;
    load_cmd && state_reg == ST_IDLE && !i_bus_init |=> o_instr.load && o_instr.acc == 12'h000;
  endproperty
  a_lcd: assert property (p_lcd) else $error("load did not clear accumulator"); // [RL9]
  property p_busy;
    load_cmd && state_reg == ST_DRIVE && !init_go && !wr_pend_reg
      |=> state_reg == ST_DRIVE && !o_instr.load;
  endproperty
  a_busy: assert property (p_busy) else $error("load taken while busy"); // [RL10]
  property p_str;
    skip_req |=> o_instr.skip == $past(req_reg);
  endproperty
  a_str: assert property (p_str) else $error("request skip wrong"); // [RL16]
  property p_trclr;
    skip_req && !req_set && !init_go |=> !req_reg;
  endproperty
  a_trclr: assert property (p_trclr) else $error("request flag not cleared"); // [RL16]
  // idle is checked on the first cycle; a new load may follow at once
  property p_err;
    err_set && !init_go |=> done_reg && err_reg && state_reg == ST_IDLE;
  endproperty
  a_err: assert property (p_err) else $error("error did not set done"); // [RL18]
  property p_sdn;
    skip_done && done_reg && !done_set && !init_go |=> o_instr.skip && !o_irq;
  endproperty
  a_sdn: assert property (p_sdn) else $error("done skip wrong"); // [RL19]
  property p_ie;
    ie_i && !init_go |=> ie_reg == $past(i_instr.acc[IE_BIT]);
  endproperty
  a_ie: assert property (p_ie) else $error("irq enable wrong"); // [RL20]
  property p_gap;
    state_reg == ST_WAIT && xfer_word && !last && !init_go && !err_set
      |=> state_reg == ST_GAP && cnt_reg == (mode8_reg ? GAP8 - 1 : GAP12 - 1);
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong"); // [RL4]
  property p_gapend;
    state_reg == ST_GAP && cnt_reg == 32'h0000_0000 && !init_go && !err_set
      |=> req_reg && state_reg == ST_WAIT;
  endproperty
  a_gapend: assert property (p_gapend) else $error("request not raised"); // [RL4]
  property p_init;
    i_bus_init |=> state_reg == ST_INIT && !done_reg && !mode8_reg && esw_reg == 12'h000;
  endproperty
  a_init: assert property (p_init) else $error("bus init ignored"); // [RL22]
  property p_wrac;
    xfer_word && state_reg == ST_WAIT && func_reg == FN_FILL |=> !o_instr.load;
  endproperty
  a_wrac: assert property (p_wrac) else $error("write altered accumulator"); // [RL13]
  property p_or8;
    xfer_word && state_reg == ST_IDLE && mode8_reg && !init_go
      |=> o_instr.acc[11:8] == $past(i_instr.acc[11:8]);
  endproperty
  a_or8: assert property (p_or8) else $error("ac nibble changed"); // [RL14]
endmodule

// ===== testbench/host_cpu_model.sv
// host processor model that issues i/o transfer instructions
module host_cpu_model
  import floppy_host_io_pkg::*;
(
  // clock
  input wire logic i_clk,
  // instruction bus to the device
  output instr_req_t o_req,
  input wire instr_rsp_t i_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_req = '0;
  // ----------------------------------------------------------------
  // one instruction, valid for a single cycle
  // ----------------------------------------------------------------
  // idle bus carries junk so a stale code never passes for a real one
  task automatic issue(input logic [5:0] d, input logic [2:0] o, input logic [11:0] a,
    output logic sk, output logic ld, output logic [11:0] r);
    @(posedge i_clk);
    o_req <= '{1'b1, d, o, a};
    @(posedge i_clk);
    o_req <= '{1'b0, 6'($urandom), 3'($urandom), 12'($urandom)};
    #1;
    sk = i_rsp.skip;
    ld = i_rsp.load;
    r = i_rsp.acc;
    // answer window is two cycles wide, pulses are one cycle
    @(posedge i_clk);
    #1;
    sk = sk | i_rsp.skip;
    ld = ld | i_rsp.load;
    if (i_rsp.load) r = i_rsp.acc;
  endtask
endmodule

// ===== testbench/tb_floppy_host_io_interface.sv
// self-checking bench of the floppy host i/o interface
module tb_floppy_host_io_interface
  import floppy_host_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short counts keep the run small
  localparam int unsigned INIT_L = 50;
  logic i_clk = 0, i_reset_n = 0, i_bus_init = 0, irq, hrdy, hresp;
  logic hsel = 0, hwrite = 0, sk, ld;
  logic [1:0] htrans = 0;
  logic [2:0] sw = 3'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [11:0] rv, w, a, esw;
  logic [11:0] q[$];
  instr_req_t req;
  instr_rsp_t rsp;
  int fails = 0, n_compared = 0, cyc = 0, i;
  always #2.5 i_clk = ~i_clk;
  floppy_host_io_interface #(.DD_IF(1'b1), .GAP12(20), .GAP8(15), .INIT_LEN(INIT_L)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr(req), .i_bus_init(i_bus_init),
    .i_dev_switch(sw), .o_instr(rsp), .o_irq(irq), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata));
  host_cpu_model host (.i_clk(i_clk), .o_req(req), .i_rsp(rsp));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [2:0] o, input logic [11:0] av);
    host.issue({3'b111, sw}, o, av, sk, ld, rv);
  endtask
  // host tests the flag before moving data
  task automatic poll(input logic [2:0] o);
    int k;
    sk = 0;
    for (k = 0; k < 300 && sk !== 1'b1; k++) op(o, 12'h000);
    check("poll flag", sk, 1);
  endtask
  // single ahb-lite word transfer; master waits on hready
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(17952);
    sw <= 3'($urandom);
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1;
    // bus initialize, then interrupt enable and device code match
    @(posedge i_clk);
    i_bus_init <= 1;
    @(posedge i_clk);
    i_bus_init <= 0;
    repeat (INIT_L + 10) @(posedge i_clk);
    op(OP_IE, 12'h001);
    check("irq on", irq, 1);
    host.issue({3'b111, sw ^ 3'h1}, OP_SKIPDONE, 12'h000, sk, ld, rv);
    check("other code", sk, 0);
    host.issue({3'b011, sw}, OP_SKIPDONE, 12'h000, sk, ld, rv);
    check("high bits", sk, 0);
    op(OP_NOP, 12'hfff);
    check("nop", {sk, ld}, 0);
    op(OP_SKIPDONE, 12'h000);
    check("done skip", sk, 1);
    op(OP_SKIPDONE, 12'h000);
    check("done cleared", sk, 0);
    check("irq off", irq, 0);
    op(OP_IE, 12'h000);
    $display("test init done");
    // fill buffer in 12-bit single density, host slow at times
    op(OP_LOAD, 12'h000);
    check("load", {ld, rv}, {1'b1, 12'h000});
    poll(OP_SKIPREQ);
    for (i = 0; i < 64; i++) begin
      w = 12'($urandom);
      q.push_back(w);
      op(OP_XFER, w);
      check("word write", ld, 0);
      if (i == 0) op(OP_SKIPREQ, 12'h000);
      if (i == 0) check("gap", sk, 0);
      repeat ($urandom_range(40)) @(posedge i_clk);
      if (i < 63) poll(OP_SKIPREQ);
    end
    poll(OP_SKIPDONE);
    for (i = 0; i < 256; i++) begin
      ahb(1, A_BADR, i);
      ahb(0, A_BDAT, 0);
      check("buffer", rd[11:0], i < 64 ? q[i] : 12'h000);
    end
    esw = 12'($urandom);
    ahb(1, A_ESW, {20'h0, esw});
    op(OP_XFER, 12'h000);
    check("status word", {ld, rv}, {1'b1, esw});
    $display("test fill done");
    // busy refusal and error path
    op(OP_LOAD, 12'h004);
    check("load accepted", ld, 1);
    op(OP_LOAD, 12'h000);
    check("load busy", ld, 0);
    ahb(1, A_CTRL, 32'h0000_0002);
    op(OP_SKIPERR, 12'h000);
    check("error skip", sk, 1);
    op(OP_SKIPERR, 12'h000);
    check("error cleared", sk, 0);
    op(OP_SKIPDONE, 12'h000);
    check("error done", sk, 1);
    $display("test error done");
    // empty buffer in 8-bit mode with a two-byte command
    q.delete();
    for (i = 0; i < 128; i++) begin
      w = 12'($urandom);
      q.push_back(w);
      ahb(1, A_BADR, i);
      ahb(1, A_BDAT, {20'h0, w});
    end
    op(OP_LOAD, {4'($urandom), 8'h42});
    poll(OP_SKIPREQ);
    op(OP_XFER, {4'($urandom), 8'h00});
    for (i = 0; i < 128; i++) begin
      poll(OP_SKIPREQ);
      a = 12'($urandom);
      op(OP_XFER, a);
      check("word read", {ld, rv}, {1'b1, a[11:8], a[7:0] | q[i][7:0]});
    end
    poll(OP_SKIPDONE);
    // status word in 8-bit mode is ored into the low byte
    a = 12'($urandom);
    op(OP_XFER, a);
    check("status byte", {ld, rv}, {1'b1, a[11:8], a[7:0] | esw[7:0]});
    $display("test empty done");
    // program initialize returns to 12-bit mode and clears status
    op(OP_INIT, 12'h000);
    poll(OP_SKIPDONE);
    ahb(0, A_STAT, 0);
    check("mode after init", rd[5], 0);
    ahb(0, A_ESW, 0);
    check("status cleared", rd[11:0], 0);
    ahb(0, 8'h40, 0);
    check("unmapped", rd, 0);
    check("okay response", hresp, 0);
    $display("test reinit done");
    test_done();
  end
endmodule
